// ### common/cbb_regs.svh
// Purpose: Register offsets, field positions, reset values, opcodes and cycle counts
// Assumes: AHB-Lite word registers, decoded on the low address byte
// Notes:   Definitions only
`ifndef CBB_REGS_SVH
`define CBB_REGS_SVH

`define OFF_CTRL      8'h00
`define OFF_INSTR     8'h04
`define OFF_PC        8'h08
`define OFF_FLAGS     8'h0c
`define OFF_STATUS    8'h10

`define CTRL_START    0
`define CTRL_VARIANT  1
`define INSTR_OP_LSB  0
`define INSTR_OPD_LSB 8
`define INSTR_DAT_LSB 16
`define ST_BUSY       0
`define ST_DONE       1
`define ST_TAKEN      2
`define ST_ILLEGAL    3
`define ST_PIN        4
`define ST_RES_LSB    8

`define FLAG_C        0
`define FLAG_Z        1
`define FLAG_N        2
`define FLAG_I        3
`define FLAG_H        4

`define RST_FLAGS     5'h00
`define RST_PC        16'h0000
`define WORD_SIZE     3'h2

`define OP_ASR_ACC    8'h47
`define OP_ASR_IDX    8'h57
`define OP_ASR_DIR    8'h37
`define OP_ASR_IX0    8'h77
`define OP_ASR_IX1    8'h67
`define OP_BR_HI      8'h22
`define OP_BR_CC      8'h24
`define OP_BR_CS      8'h25
`define OP_BR_EQ      8'h27
`define OP_BR_HCC     8'h28
`define OP_BR_HCS     8'h29
`define OP_BR_PINL    8'h2e
`define OP_BR_PINH    8'h2f
`define OP_MEMORY_BIT_CLEAR_BASE  8'h11
`define OP_MEMORY_BIT_CLEAR_LAST  8'h1f

`define CYC_BR_STD    3'h4
`define CYC_BR_LP     3'h3
`define CYC_ASR_R_STD 3'h4
`define CYC_ASR_R_LP  3'h3
`define CYC_ASR_D_STD 3'h6
`define CYC_ASR_D_LP  3'h5
`define CYC_ASR_X_STD 3'h7
`define CYC_ASR_X_LP  3'h6
`define CYC_MEMORY_BIT_CLEAR_STD  3'h7
`define CYC_MEMORY_BIT_CLEAR_LP   3'h5
`define CYC_ILLEGAL   3'h1
`define BR_STEP       16'h0002

`endif

// ### common/cbb_pkg.sv
// Purpose: Types shared by the decode core
// Assumes: Constants live in cbb_regs.svh
// Notes:   One-hot machine codes
package cbb_pkg;

   typedef enum logic [1:0] {
      IDLE = 2'b01,
      EXEC = 2'b10
   } fsm_type;

   typedef struct packed {
      fsm_type     fsm;
      logic [2:0]  cnt;
      logic        variant;
      logic [7:0]  opcode;
      logic [7:0]  operand;
      logic [7:0]  data;
      logic [15:0] pc;
      logic [4:0]  flags;
      logic [7:0]  result;
      logic        done;
      logic        taken;
      logic        illegal;
      logic [2:0]  pin_sync;
      logic        pin_level;
      logic        pin_snap;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
   } state_type;

endpackage : cbb_pkg

// ### common/exec_if.sv
// Purpose: Carries one latched instruction to the execute unit and its outcome back
// Assumes: Core holds inputs stable while executing
// Notes:   Purely combinational path
`timescale 1ns/10ps
interface exec_if;
   logic        variant;
   logic [7:0]  opcode;
   logic [7:0]  operand;
   logic [7:0]  data;
   logic [15:0] pc;
   logic [4:0]  flags;
   logic        pin;
   logic [7:0]  result;
   logic [4:0]  flags_out;
   logic [15:0] next_pc;
   logic        taken;
   logic        legal;
   logic        is_branch;
   logic [2:0]  cycles;
   logic [2:0]  length;

   modport core (output variant, opcode, operand, data, pc, flags, pin,
                 input result, flags_out, next_pc, taken, legal, is_branch, cycles, length);
   modport unit (input variant, opcode, operand, data, pc, flags, pin,
                 output result, flags_out, next_pc, taken, legal, is_branch, cycles, length);
endinterface : exec_if

// ### logic/exec_unit.sv
// Purpose: Decode one opcode and compute result, flags, next pc and cycle count
// Assumes: Inputs held stable by the core
// Notes:   No state
`timescale 1ns/10ps
`include "cbb_regs.svh"
module exec_unit
   import cbb_pkg::*;
(
   exec_if.unit ex
);
   logic [2:0]  bit_n;
   logic [7:0]  clr_res;
   logic [15:0] rel;
   logic        is_memory_bit_clear;

   assign bit_n   = 3'((ex.opcode - `OP_MEMORY_BIT_CLEAR_BASE) >> 1);
   assign is_memory_bit_clear = (ex.opcode >= `OP_MEMORY_BIT_CLEAR_BASE) && (ex.opcode <= `OP_MEMORY_BIT_CLEAR_LAST) && ex.opcode[0];

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_clr
         assign clr_res[i] = ex.data[i] & (bit_n != 3'(i));
      end
   endgenerate

   assign rel = {{8{ex.operand[7]}}, ex.operand};

   always_comb begin
      logic arith_shift_right;
      logic cond;
      arith_shift_right          = 1'b0;
      cond         = 1'b0;
      ex.result    = ex.data;
      ex.flags_out = ex.flags;
      ex.legal     = 1'b1;
      ex.is_branch = 1'b1;
      ex.length    = 3'h2;
      ex.cycles    = ex.variant ? `CYC_BR_LP : `CYC_BR_STD;
      case (ex.opcode)
         `OP_ASR_ACC, `OP_ASR_IDX, `OP_ASR_IX0: begin
            arith_shift_right       = 1'b1;
            ex.length = 3'h1;
         end
         `OP_ASR_DIR, `OP_ASR_IX1: begin
            arith_shift_right = 1'b1;
         end
         `OP_BR_CC:   cond = !ex.flags[`FLAG_C];
         `OP_BR_CS:   cond = ex.flags[`FLAG_C];
         `OP_BR_EQ:   cond = ex.flags[`FLAG_Z];
         `OP_BR_HCC:  cond = !ex.flags[`FLAG_H];
         `OP_BR_HCS:  cond = ex.flags[`FLAG_H];
         `OP_BR_HI:   cond = !(ex.flags[`FLAG_C] | ex.flags[`FLAG_Z]);
         `OP_BR_PINH: cond = ex.pin;
         `OP_BR_PINL: cond = !ex.pin;
         default: begin
            ex.is_branch = 1'b0;
            if (is_memory_bit_clear) begin
               ex.result = clr_res;
               ex.cycles = ex.variant ? `CYC_MEMORY_BIT_CLEAR_LP : `CYC_MEMORY_BIT_CLEAR_STD;
            end else begin
               ex.legal  = 1'b0;
               ex.length = 3'h1;
               ex.cycles = `CYC_ILLEGAL;
            end
         end
      endcase
      if (arith_shift_right) begin
         ex.is_branch = 1'b0;
         ex.result    = {ex.data[7], ex.data[7:1]};
         if (ex.opcode == `OP_ASR_ACC || ex.opcode == `OP_ASR_IDX) begin
            ex.cycles = ex.variant ? `CYC_ASR_R_LP : `CYC_ASR_R_STD;
         end else if (ex.opcode == `OP_ASR_IX1) begin
            ex.cycles = ex.variant ? `CYC_ASR_X_LP : `CYC_ASR_X_STD;
         end else begin
            ex.cycles = ex.variant ? `CYC_ASR_D_LP : `CYC_ASR_D_STD;
         end
         ex.flags_out[`FLAG_N] = ex.data[7];
         ex.flags_out[`FLAG_Z] = ({ex.data[7], ex.data[7:1]} == 8'h00);
         ex.flags_out[`FLAG_C] = ex.data[0];
      end
      ex.taken   = ex.is_branch & cond;
      ex.next_pc = ex.taken ? (ex.pc + `BR_STEP + rel) : (ex.pc + {13'h0000, ex.length});
   end
endmodule : exec_unit

// ### logic/cond_branch_bit_ops.sv
// Purpose: Shift, bit clear and conditional branch execution behind AHB-Lite
// Assumes: Single word transfers; software loads operands then starts
// Notes:   Zero wait states; response always OKAY
`timescale 1ns/10ps
`include "cbb_regs.svh"
module cond_branch_bit_ops
   import cbb_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic        irq_pin,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp
);
   localparam state_type RST_STATE = '{fsm:       IDLE,
                                       pc:        `RST_PC,
                                       flags:     `RST_FLAGS,
                                       hreadyout: 1'b1,
                                       default:   '0};

   state_type s;
   state_type next_s;
   logic      addr_ok;
   logic      busy;
   logic      commit;
   exec_if    ex ();

   assign ex.variant = s.variant;
   assign ex.opcode  = s.opcode;
   assign ex.operand = s.operand;
   assign ex.data    = s.data;
   assign ex.pc      = s.pc;
   assign ex.flags   = s.flags;
   assign ex.pin     = s.pin_snap;

   exec_unit u_exec (
      .ex (ex)
   );

   assign busy    = (s.fsm == EXEC);
   assign commit  = busy && (s.cnt == ex.cycles - 3'h1);
   assign addr_ok = hsel && htrans[1] && hready;

   function automatic logic [31:0] read_word(input state_type st, input logic [7:0] a);
      logic [31:0] w;
      w = '0;
      case (a)
         `OFF_CTRL:  w[`CTRL_VARIANT] = st.variant;
         `OFF_INSTR: w[23:0] = {st.data, st.operand, st.opcode};
         `OFF_PC:    w[15:0] = st.pc;
         `OFF_FLAGS: w[4:0] = st.flags;
         `OFF_STATUS: begin
            w[`ST_BUSY]           = (st.fsm == EXEC);
            w[`ST_DONE]           = st.done;
            w[`ST_TAKEN]          = st.taken;
            w[`ST_ILLEGAL]        = st.illegal;
            w[`ST_PIN]            = st.pin_level;
            w[`ST_RES_LSB +: 8]   = st.result;
         end
         default: w = '0;
      endcase
      return w;
   endfunction : read_word

   always_comb begin
      next_s = s;
      // Pin level accepted only once two later stages agree
      next_s.pin_sync = {s.pin_sync[1:0], irq_pin};
      if (s.pin_sync[1] == s.pin_sync[2]) begin
         next_s.pin_level = s.pin_sync[2];
      end

      next_s.wr_pend = 1'b0;
      if (addr_ok) begin
         next_s.wr_pend = hwrite && (hsize == `WORD_SIZE);
         next_s.wr_addr = haddr[7:0];
         if (!hwrite) begin
            next_s.hrdata = read_word(s, haddr[7:0]);
         end
      end

      // Operands frozen while executing so the outcome stays consistent
      if (s.wr_pend && !busy) begin
         case (s.wr_addr)
            `OFF_CTRL: begin
               next_s.variant = hwdata[`CTRL_VARIANT];
               if (hwdata[`CTRL_START]) begin
                  next_s.fsm      = EXEC;
                  next_s.cnt      = 3'h0;
                  next_s.done     = 1'b0;
                  next_s.pin_snap = s.pin_level;
               end
            end
            `OFF_INSTR: begin
               next_s.opcode  = hwdata[`INSTR_OP_LSB +: 8];
               next_s.operand = hwdata[`INSTR_OPD_LSB +: 8];
               next_s.data    = hwdata[`INSTR_DAT_LSB +: 8];
            end
            `OFF_PC:    next_s.pc = hwdata[15:0];
            `OFF_FLAGS: next_s.flags = hwdata[4:0];
            default: begin
            end
         endcase
      end

      if (busy) begin
         if (commit) begin
            next_s.fsm     = IDLE;
            next_s.done    = 1'b1;
            next_s.taken   = ex.taken;
            next_s.illegal = !ex.legal;
            next_s.result  = ex.result;
            next_s.flags   = ex.flags_out;
            next_s.pc      = ex.next_pc;
         end else begin
            next_s.cnt = s.cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= RST_STATE;
      end else begin
         s <= next_s;
      end
   end

   assign hrdata    = s.hrdata;
   assign hreadyout = s.hreadyout;
   assign hresp     = s.hresp;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   br_len_std_a: assert property (
      busy && !$past(busy) && ex.is_branch && !s.variant |-> busy[*4] ##1 !busy)
      else $error("standard branch not four cycles");

   br_len_lp_a: assert property (
      busy && !$past(busy) && ex.is_branch && s.variant |-> busy[*3] ##1 !busy)
      else $error("low power branch not three cycles");

   br_flags_kept_a: assert property (
      commit && ex.is_branch |=> s.flags == $past(s.flags))
      else $error("branch changed flags");

   br_target_a: assert property (
      commit && ex.taken |=>
      s.pc == $past(s.pc) + `BR_STEP + {{8{s.operand[7]}}, s.operand})
      else $error("taken branch target wrong");

   br_fall_through_a: assert property (
      commit && ex.is_branch && !ex.taken |=> s.pc == $past(s.pc) + `BR_STEP)
      else $error("untaken branch did not fall through");

   carry_clear_a: assert property (
      commit && s.opcode == `OP_BR_CC |=> s.taken == !s.flags[`FLAG_C])
      else $error("carry clear decision wrong");

   carry_set_a: assert property (
      commit && s.opcode == `OP_BR_CS |=> s.taken == s.flags[`FLAG_C])
      else $error("carry set decision wrong");

   zero_set_a: assert property (
      commit && s.opcode == `OP_BR_EQ |=> s.taken == s.flags[`FLAG_Z])
      else $error("equal decision wrong");

   half_clear_a: assert property (
      commit && s.opcode == `OP_BR_HCC |=> s.taken == !s.flags[`FLAG_H])
      else $error("half carry clear decision wrong");

   half_set_a: assert property (
      busy && s.opcode == `OP_BR_HCS && !s.flags[`FLAG_H] |-> ##[1:4] (s.done && !s.taken))
      else $error("half carry set decision wrong");

   higher_a: assert property (
      commit && s.opcode == `OP_BR_HI |=>
      s.taken == !(s.flags[`FLAG_C] | s.flags[`FLAG_Z]))
      else $error("higher decision wrong");

   pin_high_a: assert property (
      commit && s.opcode == `OP_BR_PINH |=> s.taken == s.pin_snap)
      else $error("pin high decision wrong");

   pin_low_a: assert property (
      commit && s.opcode == `OP_BR_PINL |=> s.taken == !s.pin_snap)
      else $error("pin low decision wrong");

   pin_snap_a: assert property (
      busy && !$past(busy) |-> s.pin_snap == $past(s.pin_level))
      else $error("pin snapshot wrong");

   // Filter only moves once stages agree
   pin_filter_a: assert property (
      $changed(s.pin_level) |-> $past(s.pin_sync[1]) == $past(s.pin_sync[2]))
      else $error("pin level moved before filter agreed");

   shift_flags_a: assert property (
      commit && (s.opcode == `OP_ASR_ACC || s.opcode == `OP_ASR_IX1) |=>
      s.flags[`FLAG_C] == s.data[0] && s.flags[`FLAG_N] == s.data[7]
      && s.flags[`FLAG_I] == $past(s.flags[`FLAG_I]))
      else $error("shift flags wrong");

   shift_mask_a: assert property (
      commit && (s.opcode == `OP_ASR_IDX || s.opcode == `OP_ASR_DIR
                 || s.opcode == `OP_ASR_IX0) |=>
      s.flags[`FLAG_N] == s.result[7] && s.flags[`FLAG_Z] == (s.result == 8'h00)
      && s.flags[`FLAG_I] == $past(s.flags[`FLAG_I])
      && s.flags[`FLAG_H] == $past(s.flags[`FLAG_H]))
      else $error("shift mask or sign wrong");

   shift_result_a: assert property (
      commit && s.opcode == `OP_ASR_IDX |=>
      s.result == {s.data[7], s.data[7:1]} && !s.illegal)
      else $error("index shift result wrong");

   shift_short_len_a: assert property (
      commit && (s.opcode == `OP_ASR_ACC || s.opcode == `OP_ASR_IX0) |=>
      s.pc == $past(s.pc) + 16'h0001)
      else $error("one byte shift length wrong");

   memory_bit_clear_bit2_a: assert property (
      commit && s.opcode == `OP_MEMORY_BIT_CLEAR_BASE + 8'h04 |=>
      s.result == (s.data & 8'hfb) && s.flags == $past(s.flags))
      else $error("bit clear wrong");

   memory_bit_clear_len_a: assert property (
      commit && s.opcode == `OP_MEMORY_BIT_CLEAR_BASE |=>
      s.pc == $past(s.pc) + 16'h0002 && s.result == (s.data & 8'hfe))
      else $error("bit clear length wrong");

   memory_bit_clear_bit7_a: assert property (
      commit && s.opcode == `OP_MEMORY_BIT_CLEAR_LAST |=> s.result == (s.data & 8'h7f))
      else $error("bit seven clear wrong");

   // Unknown opcode steps one byte
   illegal_op_a: assert property (
      commit && !ex.legal |=> s.illegal && s.pc == $past(s.pc) + 16'h0001)
      else $error("illegal opcode handling wrong");

   // Done marks every finish
   done_on_end_a: assert property (
      $fell(busy) |-> s.done)
      else $error("done not set at end");

   // Zero wait, always okay
   bus_okay_a: assert property (
      !hresp && hreadyout)
      else $error("bus response not okay");
endmodule : cond_branch_bit_ops

// ### testbench/cond_branch_bit_ops_tb.sv
// Purpose: Self-checking bench for the shift, bit clear and branch core
// Assumes: One zero-wait slave, hready fed from hreadyout
// Notes:   Expected values come from the bench's own model in run; t_reset and t_illegal check fixed values
`timescale 1ns/10ps
`include "cbb_regs.svh"
module cond_branch_bit_ops_tb;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic        irq_pin;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   int          err_total;
   int          n_tests;

   assign hready = hreadyout;

   cond_branch_bit_ops i_cond_branch_bit_ops (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .irq_pin(irq_pin), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Holds each phase until hready is seen high at an edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      hsize <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      chk(16'(hresp), 16'h0000);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h00000000, q);
   endtask : rd

   // Late run looks one cycle past the end; early run one cycle before it
   task automatic run(input logic [7:0] op, opd, dat, input logic [15:0] pc,
                      input logic [4:0] fl, input logic v, late);
      logic [31:0] q;
      logic [15:0] epc;
      logic [4:0]  efl;
      logic [7:0]  eres;
      logic [2:0]  n;
      logic        tk;
      logic        br;
      epc = pc + 16'h0002;
      efl = fl;
      eres = dat;
      tk = 1'b0;
      br = 1'b1;
      n = v ? 3'h3 : 3'h4;
      case (op)
         8'h22: tk = !fl[0] && !fl[1];
         8'h24: tk = !fl[0];
         8'h25: tk = fl[0];
         8'h27: tk = fl[1];
         8'h28: tk = !fl[4];
         8'h29: tk = fl[4];
         8'h2e: tk = !irq_pin;
         8'h2f: tk = irq_pin;
         default: br = 1'b0;
      endcase
      if (tk)
         epc = epc + {{8{opd[7]}}, opd};
      if (op[7:4] == 4'h1) begin
         eres = dat & ~(8'h01 << op[3:1]);
         n = v ? 3'h5 : 3'h7;
      end else if (!br) begin
         eres = {dat[7], dat[7:1]};
         efl = {fl[4:3], eres[7], eres == 8'h00, dat[0]};
         n = (op == 8'h67) ? 3'h7 : (op == 8'h37 || op == 8'h77) ? 3'h6 : 3'h4;
         n = n - {2'h0, v};
         if (op != 8'h37 && op != 8'h67)
            epc = pc + 16'h0001;
      end
      wr(`OFF_INSTR, {8'h00, dat, opd, op});
      wr(`OFF_PC, {16'h0000, pc});
      wr(`OFF_FLAGS, {27'h0, fl});
      wr(`OFF_CTRL, {30'h0, v, 1'b1});
      repeat (late ? n : n - 3'h1) @(posedge hclk);
      rd(`OFF_STATUS, q);
      chk(16'(q[1:0]), late ? 16'h0002 : 16'h0001);
      if (!late)
         rd(`OFF_STATUS, q);
      if (br)
         chk(16'(q[2]), 16'(tk));
      else
         chk(16'(q[15:8]), 16'(eres));
      rd(`OFF_PC, q);
      chk(q[15:0], epc);
      rd(`OFF_FLAGS, q);
      chk(16'(q[4:0]), 16'(efl));
   endtask : run

   task automatic t_reset();
      logic [31:0] q;
      rd(`OFF_PC, q);
      chk(q[15:0], 16'h0000);
      rd(`OFF_FLAGS, q);
      chk(q[15:0], 16'h0000);
      rd(8'h20, q);
      chk(q[15:0], 16'h0000);
      $display("reset test done");
   endtask : t_reset

   task automatic t_shift();
      logic [7:0] ops [5] = '{8'h47, 8'h57, 8'h37, 8'h77, 8'h67};
      logic [7:0] dts [3] = '{8'h81, 8'h01, 8'h7e};
      for (int i = 0; i < 15; i++)
         run(ops[i % 5], 8'h10, dts[i / 5], 16'h0100, 5'h1e, i[0], 1'b0);
      $display("shift test done");
   endtask : t_shift

   // Pin set apart from the mask bit so only the raw level can steer
   task automatic t_branch();
      logic [7:0] ops [8] = '{8'h22, 8'h24, 8'h25, 8'h27, 8'h28, 8'h29, 8'h2e, 8'h2f};
      logic [4:0] fls [5] = '{5'h00, 5'h01, 5'h02, 5'h18, 5'h1f};
      for (int p = 0; p < 2; p++) begin
         irq_pin <= p[0];
         repeat (6) @(posedge hclk);
         for (int o = 0; o < 8; o++)
            for (int f = 0; f < 5; f++)
               run(ops[o], f[0] ? 8'h80 : 8'h7f, 8'h00, 16'hfff0, fls[f], f[1],
                   1'b0);
      end
      $display("branch test done");
   endtask : t_branch

   task automatic t_memory_bit_clear();
      for (int n = 0; n < 8; n++)
         run({4'h1, n[2:0], 1'b1}, 8'h40, n[0] ? 8'hff : 8'ha5, 16'h0200, 5'h1f, n[1], 1'b0);
      $display("bit clear test done");
   endtask : t_memory_bit_clear

   task automatic t_timing();
      for (int v = 0; v < 2; v++) begin
         run(8'h24, 8'hf0, 8'h00, 16'h0010, 5'h00, v[0], 1'b1);
         run(8'h24, 8'hf0, 8'h00, 16'h0010, 5'h01, v[0], 1'b1);
         run(8'h67, 8'h05, 8'h02, 16'h0020, 5'h00, v[0], 1'b1);
         run(8'h13, 8'h05, 8'h02, 16'h0020, 5'h00, v[0], 1'b1);
      end
      $display("timing test done");
   endtask : t_timing

   // Unknown opcode: one cycle, flagged, one byte step
   task automatic t_illegal();
      logic [31:0] q;
      wr(`OFF_INSTR, 32'h00000001);
      wr(`OFF_PC, 32'h00000300);
      wr(`OFF_CTRL, 32'h00000001);
      @(posedge hclk);
      rd(`OFF_STATUS, q);
      chk(16'(q[3:0]), 16'h000a);
      rd(`OFF_PC, q);
      chk(q[15:0], 16'h0301);
      $display("illegal test done");
   endtask : t_illegal

   task automatic results();
      $display("tests=%0d errors=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results

   initial begin
      repeat (40000) @(posedge hclk);
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      results();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      irq_pin = 1'b0;
      err_total = 0;
      n_tests = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_shift();
      t_branch();
      t_memory_bit_clear();
      t_timing();
      t_illegal();
      results();
   end
endmodule : cond_branch_bit_ops_tb
